// >>> enc_map.svh
`ifndef ENC_MAP_SVH
`define ENC_MAP_SVH

// timing
`define ENC_CLK_MHZ 125
`define ENC_GAP_US 40
`define ENC_ERR_BUSY_US 2000
`define ENC_POS_BUSY_US 18000
`define ENC_PWRON_US 1000
`define ENC_NV_WRITE_US 5000
`define ENC_REPEAT_COUNT 4'hA

// apb map
`define ENC_CTRL_OFF 8'h00
`define ENC_STATUS_OFF 8'h04
`define ENC_ST_POS_OFF 8'h08
`define ENC_MT_POS_OFF 8'h0C
`define ENC_NV_ADDR_OFF 8'h10
`define ENC_NV_DATA_OFF 8'h14
`define ENC_CTRL_RES_RST 5'h17

// status fields
`define ENC_STAT_BUSY 0
`define ENC_STAT_PEND 1
`define ENC_STAT_ST 2
`define ENC_STAT_PS 3
`define ENC_STAT_MT 4
`define ENC_STAT_BATTERY_LOW_ALARM 5

// offsets kept in nv storage
`define ENC_NV_MT_OFF_ADDR 7'h7A
`define ENC_NV_ST_OFF_ADDR 7'h7D

// frame
`define ENC_SF_EE0 4
`define ENC_SF_EE1 5
`define ENC_DATA_FRAME_LEN 3'h5
`define ENC_MEM_FRAME_LEN 3'h3

`endif

// >>> enc_pkg.sv
package enc_pkg;

    typedef enum logic [7:0] {
        ENC_CMD_ST_READ = 8'h02,
        ENC_CMD_MT_READ = 8'h8A,
        ENC_CMD_NV_WRITE = 8'h32,
        ENC_CMD_NV_READ = 8'hEA,
        ENC_CMD_ERR_RESET = 8'hBA,
        ENC_CMD_POS_RESET = 8'hC2,
        ENC_CMD_MT_RESET = 8'h62
    } enc_cmd_e;

    typedef logic [7:0] enc_byte_t;

endpackage : enc_pkg

// >>> enc_serial_cmd.sv
`timescale 1ns/100ps
`include "enc_map.svh"

// Notes on behaviour
// R1 - master repeats a reset code ten times, at least 40 us apart
// R2 - position reset after ten receptions clears singleturn and multiturn counts to zero
// R3 - position reset offsets live in non-volatile storage, kept across power loss
// R4 - multiturn reset clears multiturn count and count-sync, period, multiturn errors
// R5 - error-only reset clears the three latched errors, position untouched
// R6 - master sends multiturn or error reset only at 300 rpm or below
// R7 - multiturn or error reset shows busy for at most 2 ms
// R8 - position reset with its storage write completes within 18 ms
// R9 - singleturn position sent as three bytes, low byte first
// R10 - position in low resolution bits, upper bits forced to zero
// R11 - address field: address in bits 7..1, write-pending flag in bit 0
// R12 - master always sends the write-pending bit as zero
// R13 - read: echo address, return byte; during write set pending, return 00h
// R14 - write when idle accepted and echoed; during write pending set, discarded
// R15 - master verifies a write by reading the same address back
// R16 - storage data is one byte, msb in bit 7
// R17 - each frame protected by 8-bit check, polynomial x^8 + 1
// R18 - check taken lsb first over all bytes but the check byte
// R19 - check register starts at zero, xor with bit 7, shift up, load bit 0
// R20 - command codes select singleturn, multiturn, storage and reset functions
// R21 - position bytes read zero while busy
// R22 - error flags latch until reset command or power cycle
module enc_serial_cmd #(
    parameter int GAP_CYC = `ENC_GAP_US * `ENC_CLK_MHZ,
    parameter int ERR_BUSY_CYC = `ENC_ERR_BUSY_US * `ENC_CLK_MHZ,
    parameter int POS_BUSY_CYC = `ENC_POS_BUSY_US * `ENC_CLK_MHZ,
    parameter int PWRON_CYC = `ENC_PWRON_US * `ENC_CLK_MHZ,
    parameter int NV_CYC = `ENC_NV_WRITE_US * `ENC_CLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_command,
    input wire logic [7:0] rx_addr_field,
    input wire logic [7:0] rx_data,
    input wire logic [23:0] st_raw,
    input wire logic [23:0] mt_raw,
    input wire logic count_sync_error_in,
    input wire logic period_consistency_error_in,
    input wire logic multiturn_fault_in,
    input wire logic battery_low_alarm_in,
    output logic tx_valid,
    output logic [2:0] tx_len,
    output logic [7:0] tx_b0,
    output logic [7:0] tx_b1,
    output logic [7:0] tx_b2,
    output logic [7:0] tx_b3,
    output logic [7:0] tx_b4,
    output logic [7:0] tx_crc
);

    ////////////////////////////////////////////////////////////////////////////
    // check generator

    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        logic inv;
        r = c;
        for (int i = 0; i < 8; i++) begin
            inv = b[i] ^ r[7]; // R18 R17
            r = {r[6:0], inv}; // R19
        end
        return r;
    endfunction : crc_byte

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [4:0] res_reg;
    logic [6:0] nv_addr_reg;
    logic count_sync_error_reg;
    logic period_consistency_error_reg;
    logic multiturn_fault_reg;
    logic battery_low_alarm_reg;
    logic [21:0] busy_cnt_reg;
    logic [21:0] nv_cnt_reg;
    logic [12:0] gap_cnt_reg;
    logic [3:0] rep_cnt_reg;
    logic [7:0] rep_cmd_reg;
    logic [7:0] nv_mem [0:127];

    wire busy = busy_cnt_reg != 22'h0;
    wire nv_pending = nv_cnt_reg != 22'h0;

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    wire is_pos_rst = rx_command == enc_pkg::ENC_CMD_POS_RESET;
    wire is_mt_rst = rx_command == enc_pkg::ENC_CMD_MT_RESET;
    wire is_err_rst = rx_command == enc_pkg::ENC_CMD_ERR_RESET;
    wire is_rst_cmd = is_pos_rst | is_mt_rst | is_err_rst;
    wire is_st_rd = rx_command == enc_pkg::ENC_CMD_ST_READ;
    wire is_mt_rd = rx_command == enc_pkg::ENC_CMD_MT_READ;
    wire is_nv_wr = rx_command == enc_pkg::ENC_CMD_NV_WRITE;
    wire is_nv_rd = rx_command == enc_pkg::ENC_CMD_NV_READ;
    wire gap_ok = gap_cnt_reg >= GAP_CYC[12:0];
    wire rep_chain = rx_command == rep_cmd_reg && gap_ok && rep_cnt_reg != 4'h0; // R1
    wire [3:0] rep_cnt_next = rep_chain ? rep_cnt_reg + 4'h1 : 4'h1;
    wire rst_fire = rx_valid && is_rst_cmd && !busy && rep_cnt_next == `ENC_REPEAT_COUNT;
    wire fire_pos = rst_fire && is_pos_rst;
    wire fire_mt = rst_fire && is_mt_rst;
    wire fire_err = rst_fire && (is_mt_rst | is_err_rst);
    wire [6:0] rx_addr = rx_addr_field[7:1]; // R11
    wire nv_cmd_wr = rx_valid && is_nv_wr && !nv_pending; // R14

    ////////////////////////////////////////////////////////////////////////////
    // offsets and positions

    wire [23:0] st_off = {nv_mem[`ENC_NV_ST_OFF_ADDR + 7'h2], nv_mem[`ENC_NV_ST_OFF_ADDR + 7'h1],
        nv_mem[`ENC_NV_ST_OFF_ADDR]};
    wire [23:0] mt_off = {nv_mem[`ENC_NV_MT_OFF_ADDR + 7'h2], nv_mem[`ENC_NV_MT_OFF_ADDR + 7'h1],
        nv_mem[`ENC_NV_MT_OFF_ADDR]};
    wire [23:0] res_mask = 24'hFFFFFF >> (5'h18 - res_reg);
    wire [23:0] st_pos = busy ? 24'h0 : ((st_raw - st_off) & res_mask); // R21 R10
    wire [23:0] mt_pos = busy ? 24'h0 : (mt_raw - mt_off); // R21
    wire [23:0] st_new_off = st_raw;
    wire [23:0] mt_new_off = mt_raw;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire apb_acc = psel && penable;
    wire apb_done = apb_acc && pready;
    wire hit_ctrl = paddr == `ENC_CTRL_OFF;
    wire hit_status = paddr == `ENC_STATUS_OFF;
    wire hit_st = paddr == `ENC_ST_POS_OFF;
    wire hit_mt = paddr == `ENC_MT_POS_OFF;
    wire hit_addr = paddr == `ENC_NV_ADDR_OFF;
    wire hit_data = paddr == `ENC_NV_DATA_OFF;
    wire mapped = hit_ctrl | hit_status | hit_st | hit_mt | hit_addr | hit_data;
    wire apb_wr = apb_done && pwrite && mapped;
    wire res_ok = pwdata[4:0] <= 5'h18;
    wire [31:0] status_word = {26'h0, battery_low_alarm_reg, multiturn_fault_reg, count_sync_error_reg,
        period_consistency_error_reg, nv_pending, busy};
    wire [31:0] rd_mux = hit_ctrl ? {27'h0, res_reg} :
        hit_status ? (status_word | {20'h0, rep_cnt_reg, 8'h0}) :
        hit_st ? {8'h0, st_pos} :
        hit_mt ? {8'h0, mt_pos} :
        hit_addr ? {25'h0, nv_addr_reg} :
        hit_data ? {24'h0, nv_mem[nv_addr_reg]} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // nv storage, not reset: models non-volatile memory

    genvar g;
    generate
        for (g = 0; g < 128; g++) begin : g_nv
            localparam logic [6:0] A = 7'(g);
            wire wr_st = fire_pos && (A >= `ENC_NV_ST_OFF_ADDR) && (A <= `ENC_NV_ST_OFF_ADDR + 7'h2);
            wire wr_mt = (fire_pos | fire_mt) && (A >= `ENC_NV_MT_OFF_ADDR) &&
                (A <= `ENC_NV_MT_OFF_ADDR + 7'h2);
            wire wr_cmd = nv_cmd_wr && rx_addr == A;
            wire wr_apb = apb_wr && hit_data && nv_addr_reg == A;
            wire [1:0] sel_st = 2'(A - `ENC_NV_ST_OFF_ADDR);
            wire [1:0] sel_mt = 2'(A - `ENC_NV_MT_OFF_ADDR);
            always_ff @(posedge pclk) begin
                if (wr_st) begin
                    nv_mem[g] <= st_new_off[8 * sel_st +: 8]; // R2 R3
                end else if (wr_mt) begin
                    nv_mem[g] <= mt_new_off[8 * sel_mt +: 8]; // R2 R4 R3
                end else if (wr_cmd) begin
                    nv_mem[g] <= rx_data; // R16
                end else if (wr_apb) begin
                    nv_mem[g] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state

    wire apb_first = apb_acc && !pready;
    wire [31:0] prdata_next = (apb_first && !pwrite) ? rd_mux : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_first;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= apb_first && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else begin
            prdata <= prdata_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_reg <= `ENC_CTRL_RES_RST;
        end else if (apb_wr && hit_ctrl && res_ok) begin
            res_reg <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_addr_reg <= 7'h0;
        end else if (apb_wr && hit_addr) begin
            nv_addr_reg <= pwdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latched errors: set wins over clear

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_sync_error_reg <= 1'b0;
            period_consistency_error_reg <= 1'b0;
            multiturn_fault_reg <= 1'b0;
        end else begin
            count_sync_error_reg <= count_sync_error_in | (count_sync_error_reg & !fire_err); // R22 R4 R5
            period_consistency_error_reg <= period_consistency_error_in |
                (period_consistency_error_reg & !fire_err); // R22 R4 R5
            multiturn_fault_reg <= multiturn_fault_in | (multiturn_fault_reg & !fire_err); // R22 R4 R5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            battery_low_alarm_reg <= 1'b0;
        end else begin
            battery_low_alarm_reg <= battery_low_alarm_in | battery_low_alarm_reg; // R22
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // repetition counting and busy timers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_reg <= 13'h0;
        end else if (rx_valid) begin
            gap_cnt_reg <= 13'h0;
        end else if (!gap_ok) begin
            gap_cnt_reg <= gap_cnt_reg + 13'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rep_cnt_reg <= 4'h0;
            rep_cmd_reg <= 8'h0;
        end else if (rx_valid) begin
            rep_cmd_reg <= rx_command;
            rep_cnt_reg <= (is_rst_cmd && !rst_fire) ? rep_cnt_next : 4'h0; // R1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_reg <= 22'(PWRON_CYC);
        end else if (fire_pos) begin
            busy_cnt_reg <= 22'(POS_BUSY_CYC); // R8
        end else if (fire_err) begin
            busy_cnt_reg <= 22'(ERR_BUSY_CYC); // R7
        end else if (busy) begin
            busy_cnt_reg <= busy_cnt_reg - 22'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_cnt_reg <= 22'h0;
        end else if (fire_pos) begin
            nv_cnt_reg <= 22'(POS_BUSY_CYC); // R8 R3
        end else if (nv_cmd_wr) begin
            nv_cnt_reg <= 22'(NV_CYC); // R14
        end else if (nv_pending) begin
            nv_cnt_reg <= nv_cnt_reg - 22'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reply frame

    wire busy_rep = busy | rst_fire; // R7
    wire [7:0] sf = {2'h0, busy_rep | count_sync_error_reg | battery_low_alarm_reg | multiturn_fault_reg,
        period_consistency_error_reg, 4'h0};
    wire [23:0] data_word = busy_rep ? 24'h0 : (is_mt_rd ? mt_pos : st_pos); // R21
    wire is_data = is_st_rd | is_mt_rd | is_rst_cmd; // R20
    wire is_mem = is_nv_rd | is_nv_wr;
    wire [7:0] adf_echo = {rx_addr, nv_pending}; // R11 R13 R14
    wire [7:0] edf_echo = nv_pending ? 8'h00 : (is_nv_rd ? nv_mem[rx_addr] : rx_data); // R13 R14
    wire [7:0] b1_next = is_mem ? adf_echo : sf;
    wire [7:0] b2_next = is_mem ? edf_echo : data_word[7:0]; // R9
    wire [7:0] b3_next = is_mem ? 8'h00 : data_word[15:8]; // R9
    wire [7:0] b4_next = is_mem ? 8'h00 : data_word[23:16]; // R9
    wire [7:0] crc_mem = crc_byte(crc_byte(crc_byte(8'h00, rx_command), b1_next), b2_next); // R19
    wire [7:0] crc_next = is_mem ? crc_mem : crc_byte(crc_byte(crc_mem, b3_next), b4_next); // R18

    wire reply_go = rx_valid && (is_data | is_mem); // R20

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
        end else begin
            tx_valid <= reply_go;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_len <= 3'h0;
            tx_b0 <= 8'h0;
            tx_b1 <= 8'h0;
            tx_b2 <= 8'h0;
            tx_b3 <= 8'h0;
            tx_b4 <= 8'h0;
            tx_crc <= 8'h0;
        end else if (reply_go) begin
            tx_len <= is_mem ? `ENC_MEM_FRAME_LEN : `ENC_DATA_FRAME_LEN;
            tx_b0 <= rx_command;
            tx_b1 <= b1_next;
            tx_b2 <= b2_next;
            tx_b3 <= b3_next;
            tx_b4 <= b4_next;
            tx_crc <= crc_next; // R17
        end
    end

endmodule : enc_serial_cmd

// >>> encoder_serial_cmd_eeprom_crc_test.sv
`timescale 1ns/100ps
`include "enc_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, g, e); end end
module encoder_serial_cmd_eeprom_crc_test;
    localparam int GAP = 8;
    localparam int ERRB = 20;
    localparam int POSB = 40;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, re, rx_valid, tx_valid;
    logic [7:0] rx_command, rx_addr_field, rx_data, tx_b0, tx_b1, tx_b2, tx_b3, tx_b4, tx_crc;
    logic [23:0] st_raw = 24'hF23456, mt_raw = 24'h000321;
    logic count_sync_error_in = '0, period_consistency_error_in = '0;
    logic multiturn_fault_in = '0, battery_low_alarm_in = '0;
    logic [2:0] tx_len;
    logic [39:0] rb;
    logic rv;
    int miscompares = 0, num_checks = 0, cyc = 0;

    enc_serial_cmd #(.GAP_CYC(GAP), .ERR_BUSY_CYC(ERRB), .POS_BUSY_CYC(POSB), .PWRON_CYC(10), .NV_CYC(16)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rx_valid, .rx_command, .rx_addr_field, .rx_data, .st_raw, .mt_raw, .count_sync_error_in,
        .period_consistency_error_in, .multiturn_fault_in, .battery_low_alarm_in, .tx_valid, .tx_len,
        .tx_b0, .tx_b1, .tx_b2, .tx_b3, .tx_b4, .tx_crc);
    esc_master #(.GAP_CYC(GAP)) i_master (.pclk, .rx_valid, .rx_command, .rx_addr_field, .rx_data);

    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rd = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic frame(input logic [7:0] c, input logic [6:0] a, input logic [7:0] d, input int gap);
        i_master.send(c, a, d, gap);
        #1;
        rv = tx_valid;
        rb = {tx_b4, tx_b3, tx_b2, tx_b1, tx_b0};
    endtask : frame

    task automatic burst(input logic [7:0] c);
        for (int i = 0; i < 10; i++) frame(c, 7'h00, 8'h00, 1);
    endtask : burst

    task automatic errs;
        @(posedge pclk);
        {count_sync_error_in, period_consistency_error_in, multiturn_fault_in} <= 3'h7;
        @(posedge pclk);
        {count_sync_error_in, period_consistency_error_in, multiturn_fault_in} <= 3'h0;
    endtask : errs

    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, `ENC_CTRL_OFF, 32'h0);
        `CHK(rd[4:0], 5'h17)
        apb(1'b0, 8'h18, 32'h0);
        `CHK(re, 1'b1)
        for (int a = 'h7A; a < 'h80; a++) begin
            apb(1'b1, `ENC_NV_ADDR_OFF, 32'(a));
            apb(1'b1, `ENC_NV_DATA_OFF, 32'h0);
        end
        $display("test regs done");
    endtask : t_regs

    task automatic t_pos;
        frame(8'h02, 7'h00, 8'h00, 2);
        `CHK(rv, 1'b1)
        `CHK(rb[39:16], 24'h723456)
        apb(1'b0, `ENC_ST_POS_OFF, 32'h0);
        `CHK(rd, 32'h00723456)
        apb(1'b1, `ENC_CTRL_OFF, 32'h11);
        frame(8'h02, 7'h00, 8'h00, 2);
        `CHK(rb[39:16], 24'h003456)
        apb(1'b1, `ENC_CTRL_OFF, 32'h17);
        frame(8'h8A, 7'h00, 8'h00, 2);
        `CHK(rb[39:16], 24'h000321)
        frame(8'h92, 7'h00, 8'h00, 2);
        `CHK(rv, 1'b0)
        $display("test position done");
    endtask : t_pos

    task automatic t_mem;
        frame(8'h32, 7'h05, 8'hA5, 1);
        `CHK(rb[23:0], 24'hA50A32)
        frame(8'h32, 7'h05, 8'h3C, 1);
        `CHK(rb[23:8], 16'h000B)
        frame(8'hEA, 7'h05, 8'h00, 1);
        `CHK(rb[23:8], 16'h000B)
        frame(8'hEA, 7'h05, 8'h00, 17);
        `CHK(rb[23:8], 16'hA50A)
        $display("test memory done");
    endtask : t_mem

    task automatic t_errs;
        errs();
        frame(8'h02, 7'h00, 8'h00, 3);
        `CHK(rb[15:8], 8'h30)
        apb(1'b0, `ENC_STATUS_OFF, 32'h0);
        `CHK(rd[11:0], 12'h01C)
        burst(8'hBA);
        `CHK({rb[13], rb[39:16]}, 25'h1000000)
        frame(8'h02, 7'h00, 8'h00, ERRB + 1);
        `CHK(rb[39:8], 32'h72345600)
        errs();
        burst(8'h62);
        frame(8'h8A, 7'h00, 8'h00, ERRB + 1);
        `CHK(rb[39:8], 32'h00000000)
        frame(8'h02, 7'h00, 8'h00, 1);
        `CHK(rb[39:16], 24'h723456)
        $display("test error reset done");
    endtask : t_errs

    task automatic t_zero;
        burst(8'hC2);
        `CHK({rb[13], rb[39:16]}, 25'h1000000)
        frame(8'h02, 7'h00, 8'h00, POSB + 1);
        `CHK({rb[13], rb[39:16]}, 25'h0000000)
        frame(8'h8A, 7'h00, 8'h00, 1);
        `CHK(rb[39:16], 24'h000000)
        apb(1'b1, `ENC_NV_ADDR_OFF, 32'h7D);
        apb(1'b0, `ENC_NV_DATA_OFF, 32'h0);
        `CHK(rd[7:0], 8'h56)
        battery_low_alarm_in <= 1'b1;
        burst(8'hBA);
        frame(8'h02, 7'h00, 8'h00, ERRB + 1);
        `CHK(rb[15:8], 8'h20)
        $display("test position reset done");
    endtask : t_zero

    task automatic stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pos();
        t_mem();
        t_errs();
        t_zero();
        stop_test();
    end
endmodule : encoder_serial_cmd_eeprom_crc_test

bind enc_serial_cmd esc_asserts i_chk (.pclk, .presetn, .psel, .penable, .pready, .rx_valid, .rx_command,
    .rx_addr_field, .battery_low_alarm_in, .tx_valid, .tx_len, .tx_b0, .tx_b1, .tx_b2, .tx_b3, .tx_b4, .tx_crc);

// >>> esc_asserts.sv
`timescale 1ns/100ps
module esc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_command,
    input wire logic [7:0] rx_addr_field,
    input wire logic battery_low_alarm_in,
    input wire logic tx_valid,
    input wire logic [2:0] tx_len,
    input wire logic [7:0] tx_b0,
    input wire logic [7:0] tx_b1,
    input wire logic [7:0] tx_b2,
    input wire logic [7:0] tx_b3,
    input wire logic [7:0] tx_b4,
    input wire logic [7:0] tx_crc
);
    wire known = rx_command inside {8'h02, 8'h8A, 8'h32, 8'hEA, 8'hBA, 8'hC2, 8'h62};
    wire mem = tx_b0 == 8'h32 || tx_b0 == 8'hEA;

    function automatic logic [7:0] crc8(input logic [39:0] b, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n * 8; i++) begin
            c = {c[6:0], b[i] ^ c[7]};
        end
        return c;
    endfunction : crc8

    wire [7:0] crc_exp = crc8({tx_b4, tx_b3, tx_b2, tx_b1, tx_b0}, int'(tx_len));

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_reply_known: assert property (rx_valid && known |=> tx_valid && tx_b0 == $past(rx_command))
        else $error("known command without echoed reply");
    a_reply_unknown: assert property (!(rx_valid && known) |=> !tx_valid)
        else $error("reply without a known command");
    a_frame_len: assert property (tx_valid |-> tx_len == (mem ? 3'h3 : 3'h5))
        else $error("reply length wrong for command");
    a_frame_crc: assert property (tx_valid |-> tx_crc == crc_exp)
        else $error("reply check byte wrong");
    a_mem_echo: assert property (tx_valid && mem |-> tx_b1[7:1] == $past(rx_addr_field[7:1]) && tx_b3 == 8'h00)
        else $error("memory reply address not echoed");
    a_battery_latch: assert property ($past(battery_low_alarm_in, 2) && tx_valid && !mem |-> tx_b1[5])
        else $error("battery alarm not shown in status");
endmodule : esc_asserts

// >>> esc_master.sv
`timescale 1ns/100ps
module esc_master #(
    parameter int GAP_CYC = 8
) (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_command,
    output logic [7:0] rx_addr_field,
    output logic [7:0] rx_data
);
    initial begin
        rx_valid = '0;
        rx_command = 8'hFF;
        rx_addr_field = 8'hFF;
        rx_data = 8'hFF;
    end

    task automatic send(input logic [7:0] c, input logic [6:0] a, input logic [7:0] d, input int gap);
        int g;
        g = (c inside {8'hBA, 8'hC2, 8'h62} && gap < GAP_CYC) ? GAP_CYC : gap;
        repeat (g) @(posedge pclk);
        rx_valid <= 1'b1;
        rx_command <= c;
        rx_addr_field <= {a, 1'b0};
        rx_data <= d;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_command <= ~c;
        rx_addr_field <= ~{a, 1'b0};
        rx_data <= ~d;
    endtask : send
endmodule : esc_master
